/* File: hdl/host_port_pkg.sv */
// Purpose: constants and carrier types for the host port second control register
// Assumes: byte-wide host port registers
// Notes:   error codes follow the two-bit status field layout
package host_port_pkg;
  localparam logic [3:0] ctrl_two_addr   = 4'h1;
  localparam logic [3:0] status_addr     = 4'h3;
  localparam logic [3:0] cfg_data_addr   = 4'h4;
  localparam int         bit_irq_cfg     = 0;
  localparam int         bit_irq_err     = 1;
  localparam int         bit_irq_usr     = 2;
  localparam int         bit_daisy       = 3;
  localparam int         bit_hold        = 4;
  localparam int         bit_user_mode   = 5;
  localparam logic [7:0] ctrl_two_reset  = 8'h00;
  localparam logic [7:0] ctrl_two_mask   = 8'h3f;
  localparam int         st_err_lsb      = 3;
  localparam logic [1:0] err_none        = 2'h0;
  localparam logic [1:0] err_ident       = 2'h1;
  localparam logic [1:0] err_checksum    = 2'h2;
  localparam logic [1:0] err_stop_align  = 2'h3;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic [7:0] ctrl_two;
    logic [7:0] rdata;
    logic       ack;
    logic       busy;
    logic       irq_n;
    logic       daisy_out_en;
    logic       user_mode_on;
    logic       ser_start;
    logic [7:0] ser_byte;
    logic [1:0] err_code;
    logic       usr_s1;
    logic       usr_s2;
  } ctrl_state_t;
endpackage

/* File: hdl/host_port_control_two.sv */
// Purpose: host port second control register and the behaviour it steers
// Assumes: host strobes are one-cycle pulses on clock; user irq comes from another domain
// Notes:   status register bits other than the error field are supplied by the caller
//
// Summary of operation
// R1: control register two is host writable and reads back written bits.
// R2: bit 0 enables interrupt on daisy-chain configuration data request.
// R3: bit 0 only acts during daisy-chain configuration.
// R4: bit 1 enables interrupt on bit stream error while configuring.
// R5: bit 2 forwards user interrupt when user request line is low.
// R6: bit 3 passes configuration data to the daisy-chain output.
// R7: bit 4 with bit 3 set withholds data write acknowledge until byte is serialized.
// R8: bytes are serialized only while daisy-chain output enable is set.
// R9: bit 4 clear acknowledges configuration data writes immediately.
// R10: host should poll status or wait for interrupt before next byte.
// R11: host sets user mode enable before configuration done rises.
// R12: bit stream request also enables user mode, regardless of bit 5.
// R13: status register is read only; writes leave it unchanged.
// R14: reserved bits 6 and 7 ignore writes and read zero.
// R15: user logic requests an interrupt by driving its line low.
// R16: error field codes none, ident, checksum, stop-bit or alignment.
`timescale 1ns/1ps
`default_nettype none
module host_port_control_two
  import host_port_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire host_req_t  host_req,
  input  wire logic       daisy_chain_mode,
  input  wire logic       config_mode,
  input  wire logic       cfg_data_request,
  input  wire logic       bit_stream_error,
  input  wire logic [1:0] bit_stream_error_code,
  input  wire logic       bitstream_user_mode,
  input  wire logic       user_irq_request_n,
  input  wire logic       ser_done,
  input  wire logic [7:0] status_other,
  output logic [7:0]      host_rdata,
  output logic            host_ack,
  output logic            host_irq_n,
  output logic            daisy_chain_output_enable,
  output logic            host_port_user_mode_enable,
  output logic            ser_start,
  output logic [7:0]      ser_byte,
  output logic [7:0]      ctrl_two
);
  ctrl_state_t s;
  ctrl_state_t next_s;

  logic user_irq_enable;
  logic cfg_irq_enable;
  logic err_irq_enable;
  logic hold_en;
  logic cfg_wr;
  logic irq_any;
  logic [7:0] status_byte;

  always_comb begin
    cfg_irq_enable  = s.ctrl_two[bit_irq_cfg];
    err_irq_enable  = s.ctrl_two[bit_irq_err];
    user_irq_enable = s.ctrl_two[bit_irq_usr];
    hold_en         = s.ctrl_two[bit_hold];
    cfg_wr          = host_req.wr && (host_req.addr == cfg_data_addr);
    status_byte     = status_other;
    status_byte[st_err_lsb +: 2] = s.err_code; // R16
    irq_any = (cfg_irq_enable && daisy_chain_mode && cfg_data_request)   // R2 R3
            || (err_irq_enable && config_mode && bit_stream_error)       // R4
            || (user_irq_enable && !s.usr_s2);                           // R5 R15
  end

  always_comb begin
    next_s           = s;
    next_s.usr_s1    = user_irq_request_n;
    next_s.usr_s2    = s.usr_s1;
    next_s.ack       = 1'b0;
    next_s.ser_start = 1'b0;
    if (bit_stream_error) begin
      next_s.err_code = bit_stream_error_code; // R16
    end
    if (host_req.wr && host_req.addr == ctrl_two_addr) begin
      next_s.ctrl_two = host_req.wdata & ctrl_two_mask; // R1 R14
    end
    // status writes are acknowledged but store nothing, so a write never changes its contents
    if (host_req.wr && host_req.addr == status_addr) begin
      next_s.ack = 1'b1; // R13
    end
    if (host_req.rd) begin
      next_s.ack = 1'b1;
      unique case (host_req.addr)
        ctrl_two_addr: next_s.rdata = s.ctrl_two; // R1
        status_addr:   next_s.rdata = status_byte;
        default:       next_s.rdata = 8'h00;
      endcase
    end
    if (cfg_wr) begin
      next_s.ser_byte = host_req.wdata;
      next_s.ser_start = s.ctrl_two[bit_daisy]; // R8
      if (hold_en && s.ctrl_two[bit_daisy]) begin
        next_s.busy = 1'b1; // R7
      end else begin
        next_s.ack = 1'b1; // R9
      end
    end
    // without daisy enable nothing serializes, so a held ack would hang
    if (s.busy && (ser_done || !s.ctrl_two[bit_daisy])) begin
      next_s.busy = 1'b0;
      next_s.ack  = 1'b1; // R7
    end
    next_s.irq_n        = !irq_any;
    next_s.daisy_out_en = s.ctrl_two[bit_daisy]; // R6
    next_s.user_mode_on = s.ctrl_two[bit_user_mode] || bitstream_user_mode; // R12
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '{ctrl_two: ctrl_two_reset, rdata: 8'h00, ack: 1'b0, busy: 1'b0,
             irq_n: 1'b1, daisy_out_en: 1'b0, user_mode_on: 1'b0, ser_start: 1'b0,
             ser_byte: 8'h00, err_code: err_none, usr_s1: 1'b1, usr_s2: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign host_rdata                 = s.rdata;
  assign host_ack                   = s.ack;
  assign host_irq_n                 = s.irq_n;
  assign daisy_chain_output_enable  = s.daisy_out_en;
  assign host_port_user_mode_enable = s.user_mode_on;
  assign ser_start                  = s.ser_start;
  assign ser_byte                   = s.ser_byte;
  assign ctrl_two                   = s.ctrl_two;

  property p_ctrl_write;
    @(posedge clock) disable iff (sys_rst)
      (host_req.wr && host_req.addr == ctrl_two_addr)
        |=> (ctrl_two == ($past(host_req.wdata) & ctrl_two_mask));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write lost"); // R1

  property p_reserved_zero;
    @(posedge clock) disable iff (sys_rst) ctrl_two[7:6] == 2'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // R14

  property p_cfg_irq;
    @(posedge clock) disable iff (sys_rst)
      (ctrl_two[bit_irq_cfg] && daisy_chain_mode && cfg_data_request) |=> !host_irq_n;
  endproperty
  a_cfg_irq: assert property (p_cfg_irq) else $error("cfg irq missing"); // R2

  property p_err_irq;
    @(posedge clock) disable iff (sys_rst)
      (ctrl_two[bit_irq_err] && config_mode && bit_stream_error) |=> !host_irq_n;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("err irq missing"); // R4

  property p_no_irq;
    @(posedge clock) disable iff (sys_rst)
      (ctrl_two[2:0] == 3'h0) |=> host_irq_n;
  endproperty
  a_no_irq: assert property (p_no_irq) else $error("irq while disabled"); // R2 R4 R5

  property p_usr_irq;
    @(posedge clock) disable iff (sys_rst)
      (ctrl_two[bit_irq_usr] && !user_irq_request_n)[*3] |=> !host_irq_n;
  endproperty
  a_usr_irq: assert property (p_usr_irq) else $error("user irq missing"); // R5

  property p_daisy_out;
    @(posedge clock) disable iff (sys_rst)
      1'b1 |=> (daisy_chain_output_enable == $past(ctrl_two[bit_daisy]));
  endproperty
  a_daisy_out: assert property (p_daisy_out) else $error("daisy enable wrong"); // R6

  property p_hold;
    @(posedge clock) disable iff (sys_rst)
      (cfg_wr && hold_en && ctrl_two[bit_daisy] && !host_req.rd) |=> !host_ack;
  endproperty
  a_hold: assert property (p_hold) else $error("ack not held"); // R7

  property p_immediate;
    @(posedge clock) disable iff (sys_rst) (cfg_wr && !hold_en) |=> host_ack;
  endproperty
  a_immediate: assert property (p_immediate) else $error("no immediate ack"); // R9

  property p_ser_gate;
    @(posedge clock) disable iff (sys_rst) ser_start |-> daisy_chain_output_enable;
  endproperty
  a_ser_gate: assert property (p_ser_gate) else $error("serialize without daisy"); // R8

  property p_user_mode;
    @(posedge clock) disable iff (sys_rst) bitstream_user_mode |=> host_port_user_mode_enable;
  endproperty
  a_user_mode: assert property (p_user_mode) else $error("user mode missing"); // R12

  property p_err_code;
    @(posedge clock) disable iff (sys_rst)
      bit_stream_error |=> (s.err_code == $past(bit_stream_error_code));
  endproperty
  a_err_code: assert property (p_err_code) else $error("error code wrong"); // R16

  // outside daisy-chain mode bit 0 alone must never pull the interrupt
  property p_cfg_only_daisy;
    @(posedge clock) disable iff (sys_rst)
      (!daisy_chain_mode && !ctrl_two[bit_irq_err] && !ctrl_two[bit_irq_usr]) |=> host_irq_n;
  endproperty
  a_cfg_only_daisy: assert property (p_cfg_only_daisy) else $error("cfg irq outside daisy"); // R3

  // a status write must not disturb the latched error field
  property p_status_ro;
    @(posedge clock) disable iff (sys_rst)
      (host_req.wr && host_req.addr == status_addr && !bit_stream_error) |=> $stable(s.err_code);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status changed by write"); // R13

  // a held write is released by the serializer finishing its byte
  property p_busy_release;
    @(posedge clock) disable iff (sys_rst) (s.busy && ser_done) |=> host_ack;
  endproperty
  a_busy_release: assert property (p_busy_release) else $error("held ack not released"); // R7

  c_hold_release: cover property (@(posedge clock) disable iff (sys_rst)
    s.busy ##1 host_ack);
  c_usr_irq: cover property (@(posedge clock) disable iff (sys_rst) $fell(host_irq_n));
  c_ctrl_read: cover property (@(posedge clock) disable iff (sys_rst)
    host_req.rd && host_req.addr == ctrl_two_addr);
  c_held_start: cover property (@(posedge clock) disable iff (sys_rst)
    ser_start && s.busy);
  c_status_write: cover property (@(posedge clock) disable iff (sys_rst)
    host_req.wr && host_req.addr == status_addr);
endmodule
`default_nettype wire

/* File: tb/host_model.sv */
// Purpose: host master issuing one-cycle register strobes
// Assumes: an ack comes within 40 cycles or never
// Notes:   ok stays low when no ack arrives
`timescale 1ns/1ps
`default_nettype none
module host_model
  import host_port_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       host_ack,
  input  wire logic [7:0] host_rdata,
  output var host_req_t   host_req
);
  initial host_req = '0;

  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic ok);
    int n;
    @(negedge clock);
    host_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clock);
    host_req <= '0;
    ok = 0;
    for (n = 0; n < 40 && !ok; n++) begin
      if (host_ack === 1'b1) ok = 1;
      else @(negedge clock);
    end
    q = host_rdata;
  endtask
endmodule
`default_nettype wire

/* File: tb/host_port_control_two_tb_top.sv */
// Purpose: self-checking bench for the second control register
// Assumes: inputs change on the falling edge
// Notes:   a local process plays the serializer with random delays
`timescale 1ns/1ps
`default_nettype none
module host_port_control_two_tb_top;
  import host_port_pkg::*;
  logic clock, sys_rst, daisy_chain_mode, config_mode, cfg_data_request, bit_stream_error;
  logic bitstream_user_mode, user_irq_request_n, ser_done, host_ack, host_irq_n, ser_start;
  logic daisy_chain_output_enable, host_port_user_mode_enable, ok, done_seen;
  logic [1:0] bit_stream_error_code;
  logic [7:0] status_other, host_rdata, ser_byte, ctrl_two, q, d;
  host_req_t  host_req;
  int         err_count = 0, n_tests = 0, cyc = 0, seed = 32'h61618ac4, i;

  host_port_control_two dut_u (.clock, .sys_rst, .host_req, .daisy_chain_mode, .config_mode,
    .cfg_data_request, .bit_stream_error, .bit_stream_error_code, .bitstream_user_mode,
    .user_irq_request_n, .ser_done, .status_other, .host_rdata, .host_ack, .host_irq_n,
    .daisy_chain_output_enable, .host_port_user_mode_enable, .ser_start, .ser_byte, .ctrl_two);
  host_model host_u (.clock, .host_ack, .host_rdata, .host_req);

  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  function automatic logic exp_irq(logic [7:0] c);
    return !((c[bit_irq_cfg] & daisy_chain_mode & cfg_data_request)
           | (c[bit_irq_err] & config_mode & bit_stream_error)
           | (c[bit_irq_usr] & !user_irq_request_n));
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    host_u.xfer(1'b1, a, v, q, ok);
  endtask

  task automatic rd(input logic [3:0] a);
    host_u.xfer(1'b0, a, 8'h00, q, ok);
  endtask

  // serializer stand-in: slow and variable so a held ack really has to wait
  initial forever begin
    @(posedge clock);
    if (ser_start === 1'b1) begin
      repeat (3 + ($random(seed) & 7)) @(negedge clock);
      ser_done = 1;
      done_seen = 1;
      @(negedge clock);
      ser_done = 0;
    end
  end

  initial begin
    {sys_rst, daisy_chain_mode, config_mode, cfg_data_request, bit_stream_error} = 5'b10000;
    {bitstream_user_mode, ser_done, done_seen, bit_stream_error_code} = '0;
    user_irq_request_n = 1;
    status_other = 8'($random(seed));
    repeat (12) @(negedge clock);
    sys_rst = 0;
    chk("reset ctrl", ctrl_two_reset, ctrl_two);
    chk("reset irq", 8'h01, {7'h0, host_irq_n});
    for (i = 0; i < 12; i++) begin
      d = (i == 0) ? 8'hff : 8'($random(seed));
      bitstream_user_mode = 1'($random(seed));
      wr(ctrl_two_addr, d);
      rd(ctrl_two_addr);
      chk("ctrl readback", d & ctrl_two_mask, q);
      chk("ctrl port", d & ctrl_two_mask, ctrl_two);
      chk("daisy en", {7'h0, d[bit_daisy]}, {7'h0, daisy_chain_output_enable});
      chk("user mode", {7'h0, d[bit_user_mode] | bitstream_user_mode},
          {7'h0, host_port_user_mode_enable});
      {daisy_chain_mode, config_mode, cfg_data_request, bit_stream_error,
       user_irq_request_n} = 5'($random(seed));
      repeat (5) @(negedge clock);
      chk("irq", {7'h0, exp_irq(d)}, {7'h0, host_irq_n});
    end
    for (i = 0; i < 4; i++) begin
      bit_stream_error_code = 2'(i);
      status_other = 8'($random(seed));
      bit_stream_error = 1;
      @(negedge clock);
      bit_stream_error = 0;
      wr(status_addr, 8'hff);
      chk("status wr ack", 8'h01, {7'h0, ok});
      rd(status_addr);
      chk("status", {status_other[7:5], bit_stream_error_code, status_other[2:0]}, q);
    end
    wr(4'hf, 8'h5a);
    chk("unmapped ack", 8'h00, {7'h0, ok});
    rd(4'hf);
    chk("unmapped rd", 8'h00, q);
    for (i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'h18 : (i == 1) ? 8'h08 : 8'h10;
      wr(ctrl_two_addr, d);
      rd(status_addr);
      done_seen = 0;
      wr(cfg_data_addr, 8'ha5 ^ 8'(i));
      chk("cfg ack", 8'h01, {7'h0, ok});
      chk("held", {7'h0, d[bit_hold] & d[bit_daisy]}, {7'h0, done_seen});
      if (d[bit_daisy]) chk("ser byte", 8'ha5 ^ 8'(i), ser_byte);
      repeat (12) @(negedge clock);
      chk("ser start", {7'h0, d[bit_daisy]}, {7'h0, done_seen});
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
